// ==== sbt_pkg.sv ====
// Constants, state codes and carriers for the SRAM boundary-scan test port
package sbt_pkg;

	// ==========================================================
	// Register sizes and boundary register layout
	localparam int IR_W        = 3;
	localparam int ID_W        = 32;
	localparam int BSR_IN      = 8;
	localparam int BSR_OUT     = 8;
	localparam int BSR_OUT_LSB = BSR_IN;
	localparam int BSR_LEN     = BSR_IN + BSR_OUT + 1;
	localparam int OE_CELL     = BSR_LEN - 1;

	// ==========================================================
	// Instruction codes; 011, 101 and 110 are reserved
	localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
	localparam logic [IR_W-1:0] IR_IDCODE  = 3'h1;
	localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;
	localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h4;
	localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
	localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

	// Update latch after reset: output-enable cell high, data low
	localparam logic [BSR_LEN-1:0] PRE_RESET = 17'h10000;

	// ==========================================================
	// Controller states
	typedef enum logic [15:0] {
		S_TLR    = 16'h0001,
		S_RTI    = 16'h0002,
		S_SEL_DR = 16'h0004,
		S_CAP_DR = 16'h0008,
		S_SH_DR  = 16'h0010,
		S_EX1_DR = 16'h0020,
		S_PAU_DR = 16'h0040,
		S_EX2_DR = 16'h0080,
		S_UPD_DR = 16'h0100,
		S_SEL_IR = 16'h0200,
		S_CAP_IR = 16'h0400,
		S_SH_IR  = 16'h0800,
		S_EX1_IR = 16'h1000,
		S_PAU_IR = 16'h2000,
		S_EX2_IR = 16'h4000,
		S_UPD_IR = 16'h8000
	} sbt_state_t;

	typedef enum logic [1:0] {
		SEL_BYP = 2'h0,
		SEL_ID  = 2'h1,
		SEL_BSR = 2'h2
	} sbt_sel_t;

	// Output pins of the memory: data and a common enable
	typedef struct packed {
		logic [BSR_OUT-1:0] dat;
		logic               oe;
	} sbt_out_t;

	// ==========================================================
	// Data register chosen by an instruction; reserved picks bypass
	function automatic sbt_sel_t sel_of(input logic [IR_W-1:0] ir);
		sbt_sel_t s;
		s = SEL_BYP;
		if (ir == IR_IDCODE)
			s = SEL_ID;
		else if (ir == IR_EXTEST || ir == IR_SAMPLE || ir == IR_SAMPLEZ)
			s = SEL_BSR;
		return s;
	endfunction

endpackage

// ==== sbt_sync.sv ====
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/100ps
module sbt_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// ==========================================================
	// First stage feeds only the second
	always_ff @(posedge clk) begin
		meta <= d;
		q    <= meta;
	end
endmodule

// ==== sbt_tap_fsm.sv ====
// Sixteen-state test-access controller advanced by the test clock
`timescale 1ns/100ps
module sbt_tap_fsm (
	input  wire logic          tck,
	input  wire logic          tap_rst,
	input  wire logic          tms,
	output sbt_pkg::sbt_state_t st
);
	import sbt_pkg::*;

	sbt_state_t next_st;

	// ==========================================================
	// Next state from TMS
	always_comb begin
		case (st)
		S_TLR:    next_st = tms ? S_TLR    : S_RTI;
		S_RTI:    next_st = tms ? S_SEL_DR : S_RTI;
		S_SEL_DR: next_st = tms ? S_SEL_IR : S_CAP_DR;
		S_CAP_DR: next_st = tms ? S_EX1_DR : S_SH_DR;
		S_SH_DR:  next_st = tms ? S_EX1_DR : S_SH_DR;
		S_EX1_DR: next_st = tms ? S_UPD_DR : S_PAU_DR;
		S_PAU_DR: next_st = tms ? S_EX2_DR : S_PAU_DR;
		S_EX2_DR: next_st = tms ? S_UPD_DR : S_SH_DR;
		S_UPD_DR: next_st = tms ? S_SEL_DR : S_RTI;
		S_SEL_IR: next_st = tms ? S_TLR    : S_CAP_IR;
		S_CAP_IR: next_st = tms ? S_EX1_IR : S_SH_IR;
		S_SH_IR:  next_st = tms ? S_EX1_IR : S_SH_IR;
		S_EX1_IR: next_st = tms ? S_UPD_IR : S_PAU_IR;
		S_PAU_IR: next_st = tms ? S_EX2_IR : S_PAU_IR;
		S_EX2_IR: next_st = tms ? S_UPD_IR : S_SH_IR;
		S_UPD_IR: next_st = tms ? S_SEL_DR : S_RTI;
		default:  next_st = S_TLR;
		endcase
	end

	// ==========================================================
	// State register, sampled on the rising test clock
	always_ff @(posedge tck) begin
		if (tap_rst)
			st <= S_TLR;
		else
			st <= next_st;
	end
endmodule

// ==== sbt_tap.sv ====
// Boundary-scan test access port of the synchronous SRAM
//
// Behaviour
// - TMS, TDI and all test inputs are sampled on rising TCK only.
// - TDO and other test outputs change only on falling TCK.
// - TDO is driven only in shift states, otherwise high impedance.
// - Data enters at the selected register's MSB, leaves at its LSB.
// - Five rising edges with TMS high bring the controller to reset.
// - Test-port reset leaves normal memory operation untouched.
// - Power-up resets the port so TDO starts high impedance; here only if TCK runs while rst is high.
// - The current instruction connects exactly one data register.
// - Instruction register is three bits, loaded serially from TDI.
// - Instruction is IDCODE after power-up and in the reset state.
// - Capture-IR loads 01 into the two instruction LSBs.
// - One-bit bypass cleared on capture, shifted under BYPASS.
// - Boundary register captures the I/O ring, then shifts.
// - IDCODE capture loads a fixed 32-bit value, then shifts it out.
// - Instructions shift in Shift-IR and take effect at Update-IR.
// - EXTEST drives preloaded cells onto outputs, selects boundary.
// - IDCODE shifts the identification value out in Shift-DR.
// - SAMPLE Z floats all memory outputs, selects boundary register.
// - SAMPLE/PRELOAD capture snapshots all input and output pins.
// - Preload data shifted in lands in update latches at Update-DR.
// - Output-enable cell presets high at power-up and in reset.
// - Identification LSB is a constant one.
`timescale 1ns/100ps
module sbt_tap #(
	// Arbitrary identification value; bit zero is forced to one
	parameter logic [31:0] ID_VALUE = 32'h0a5a_5001
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         tck,
	input  wire logic                         tms,
	input  wire logic                         tdi,
	output logic                              tdo,
	output logic                              tdo_oe,
	input  wire logic [sbt_pkg::BSR_IN-1:0]   pin_in,
	input  wire sbt_pkg::sbt_out_t            core_out,
	output sbt_pkg::sbt_out_t                 pad_out
);
	import sbt_pkg::*;

	// ==========================================================
	// Declarations
	logic [ID_W-1:0]    id_const;
	logic               tap_rst;
	sbt_state_t         st;
	logic [IR_W-1:0]    ir;
	logic [IR_W-1:0]    ir_sh;
	logic               byp;
	logic [ID_W-1:0]    id_sh;
	logic [BSR_LEN-1:0] bsr_sh;
	logic [BSR_LEN-1:0] pre;
	logic               pre_tgl;
	logic [BSR_LEN-1:0] ring;
	logic [BSR_LEN-1:0] ring_tck;
	sbt_sel_t           sel;
	logic               in_tlr;
	logic               cap_ir;
	logic               sh_ir;
	logic               upd_ir;
	logic               cap_dr;
	logic               sh_dr;
	logic               upd_dr;
	logic               sel_byp;
	logic               sel_id;
	logic               sel_bsr;
	logic               pre_load;
	logic               pre_back;
	logic               dr_bit;
	logic               next_tdo;
	logic [IR_W-1:0]    next_ir;
	logic               ir_move;
	logic               xfer;
	logic [IR_W-1:0]    ir_clk;
	logic               tgl_clk;
	logic               tgl_seen;
	logic               tgl_edge;
	logic [BSR_LEN-1:0] pre_clk;
	logic               ext_clk;
	logic               hz_clk;
	sbt_out_t           next_pad;

	assign id_const = {ID_VALUE[ID_W-1:1], 1'b1};

	// ==========================================================
	// Power-up reset carried into the test clock domain. The test
	// clock may stand still, so the port resets only while TCK runs.
	sbt_sync #(
		.W (1)
	) u_rst_sync (
		.clk (tck),
		.d   (rst),
		.q   (tap_rst)
	);

	sbt_tap_fsm u_fsm (
		.tck     (tck),
		.tap_rst (tap_rst),
		.tms     (tms),
		.st      (st)
	);

	// ==========================================================
	// State and instruction decode
	assign in_tlr  = (st == S_TLR);
	assign cap_ir  = (st == S_CAP_IR);
	assign sh_ir   = (st == S_SH_IR);
	assign upd_ir  = (st == S_UPD_IR);
	assign cap_dr  = (st == S_CAP_DR);
	assign sh_dr   = (st == S_SH_DR);
	assign upd_dr  = (st == S_UPD_DR);
	assign sel     = sel_of(ir);
	assign sel_byp = (sel == SEL_BYP);
	assign sel_id  = (sel == SEL_ID);
	assign sel_bsr = (sel == SEL_BSR);
	assign pre_load = upd_dr && (ir == IR_SAMPLE || ir == IR_EXTEST);
	assign pre_back = in_tlr && (pre != PRE_RESET);
	assign next_ir  = in_tlr ? IR_IDCODE : (upd_ir ? ir_sh : ir);
	assign ir_move  = (next_ir != ir);
	assign xfer     = pre_back || pre_load || ir_move;

	// ==========================================================
	// Pin states entering the test clock domain. Pins may move
	// during capture; the value caught then is not guaranteed.
	assign ring = {pad_out.oe, pad_out.dat, pin_in};

	sbt_sync #(
		.W (BSR_LEN)
	) u_ring_sync (
		.clk (tck),
		.d   (ring),
		.q   (ring_tck)
	);

	// ==========================================================
	// Instruction register
	always_ff @(posedge tck) begin
		if (tap_rst)
			ir <= IR_IDCODE;
		else
			ir <= next_ir;
	end

	always_ff @(posedge tck) begin
		if (cap_ir)
			ir_sh <= IR_CAPTURE;
		else if (sh_ir)
			ir_sh <= {tdi, ir_sh[IR_W-1:1]};
	end

	// ==========================================================
	// Data registers
	always_ff @(posedge tck) begin
		if (cap_dr && sel_byp)
			byp <= 1'b0;
		else if (sh_dr && sel_byp)
			byp <= tdi;
	end

	always_ff @(posedge tck) begin
		if (cap_dr && sel_id)
			id_sh <= id_const;
		else if (sh_dr && sel_id)
			id_sh <= {tdi, id_sh[ID_W-1:1]};
	end

	always_ff @(posedge tck) begin
		if (cap_dr && sel_bsr)
			bsr_sh <= ring_tck;
		else if (sh_dr && sel_bsr)
			bsr_sh <= {tdi, bsr_sh[BSR_LEN-1:1]};
	end

	// ==========================================================
	// Update latches; one toggle hands them and the instruction over
	always_ff @(posedge tck) begin
		if (tap_rst) begin
			pre     <= PRE_RESET;
			pre_tgl <= 1'b0;
		end else begin
			if (pre_back)
				pre <= PRE_RESET;
			else if (pre_load)
				pre <= bsr_sh;
			if (xfer)
				pre_tgl <= ~pre_tgl;
		end
	end

	// ==========================================================
	// Serial output, launched on the falling test clock
	assign dr_bit   = sel_id ? id_sh[0] : (sel_bsr ? bsr_sh[0] : byp);
	assign next_tdo = sh_ir ? ir_sh[0] : dr_bit;

	always_ff @(negedge tck) begin
		if (tap_rst) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo    <= next_tdo;
			tdo_oe <= sh_ir || sh_dr;
		end
	end

	// ==========================================================
	// Memory clock side. Instruction and latches are held steady
	// from the edge that flips the toggle, so the memory clock reads them only
	// once the toggle has passed its two flops; no torn words.
	sbt_sync #(
		.W (1)
	) u_mode_sync (
		.clk (clk),
		.d   (pre_tgl),
		.q   (tgl_clk)
	);

	assign tgl_edge = tgl_clk != tgl_seen;
	assign ext_clk  = (ir_clk == IR_EXTEST);
	assign hz_clk   = (ir_clk == IR_SAMPLEZ);

	// Core path is untouched unless EXTEST or SAMPLE Z is on
	always_comb begin
		next_pad = core_out;
		if (ext_clk) begin
			next_pad.dat = pre_clk[BSR_OUT_LSB +: BSR_OUT];
			next_pad.oe  = pre_clk[OE_CELL];
		end else if (hz_clk) begin
			next_pad.oe  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// Follow the toggle so a stopped test clock sends nothing
			tgl_seen <= tgl_clk;
			ir_clk   <= IR_IDCODE;
			pre_clk  <= PRE_RESET;
			pad_out  <= '0;
		end else begin
			tgl_seen <= tgl_clk;
			if (tgl_edge) begin
				ir_clk  <= ir;
				pre_clk <= pre;
			end
			pad_out <= next_pad;
		end
	end

	// ==========================================================
	// Checks on the test clock domain
	sequence tms_high_run;
		tms [*5];
	endsequence

	sequence ir_load;
		sh_ir ##1 (st == S_EX1_IR) ##1 upd_ir;
	endsequence

	property five_high_resets;
		@(posedge tck) disable iff (tap_rst)
		tms_high_run |=> in_tlr;
	endproperty

	property ir_takes_shift;
		@(posedge tck) disable iff (tap_rst)
		ir_load |=> (ir == $past(ir_sh));
	endproperty

	tap_reset_a: assert property (five_high_resets)
		else $error("five high TMS edges did not reach reset");

	ir_update_a: assert property (ir_takes_shift)
		else $error("instruction not taken at update");

	ir_capture_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		cap_ir |=> (ir_sh[1:0] == IR_CAPTURE[1:0]))
		else $error("capture pattern not loaded");

	ir_reset_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		in_tlr |=> (ir == IR_IDCODE))
		else $error("instruction not IDCODE after reset state");

	ir_hold_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		(sh_ir || cap_ir) |=> $stable(ir))
		else $error("instruction changed outside update");

	bypass_clear_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		(cap_dr && sel_byp) |=> !byp)
		else $error("bypass not cleared on capture");

	bypass_shift_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		(sh_dr && sel_byp) |=> (byp == $past(tdi)))
		else $error("bypass did not take the serial input");

	id_capture_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		(cap_dr && sel_id) |=> (id_sh == id_const) && id_sh[0])
		else $error("identification value not captured");

	bsr_shift_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		(sh_dr && sel_bsr) |=> (bsr_sh[OE_CELL] == $past(tdi)))
		else $error("boundary data did not enter at the top");

	tdo_enable_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		(st != S_TLR) |-> (tdo_oe == (sh_ir || sh_dr)))
		else $error("TDO driven outside shift states");

	oe_preset_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		in_tlr |=> pre[OE_CELL])
		else $error("output enable cell not preset");

	reserved_byp_a: assert property (
		@(posedge tck) disable iff (tap_rst)
		(ir == 3'h3 || ir == 3'h5 || ir == 3'h6) |-> sel_byp)
		else $error("reserved code did not select bypass");

	// ==========================================================
	// Checks on the memory clock domain
	hiz_outputs_a: assert property (
		@(posedge clk) disable iff (rst)
		hz_clk |=> !pad_out.oe)
		else $error("outputs enabled under SAMPLE Z");

	core_pass_a: assert property (
		@(posedge clk) disable iff (rst)
		(!ext_clk && !hz_clk) |=> (pad_out == $past(core_out)))
		else $error("core outputs disturbed by test port");

	extest_drive_a: assert property (
		@(posedge clk) disable iff (rst)
		ext_clk |=> (pad_out.oe == $past(pre_clk[OE_CELL])))
		else $error("preloaded enable not driven under EXTEST");

	mode_take_a: assert property (
		@(posedge clk) disable iff (rst)
		tgl_edge |=> (ir_clk == $past(ir)) && (pre_clk == $past(pre)))
		else $error("memory clock missed a test port update");
endmodule

// ==== sbt_jtag_master.sv ====
// Board-side test controller model that drives the serial test link
`timescale 1ns/100ps
module sbt_jtag_master (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	// ==========================================================
	// Link state
	// Above the 20 MHz pin limit the logic itself has no limit
	localparam time HALF = 16ns;
	logic           last_oe;
	logic           oe_ok;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		last_oe = 1'b0;
		oe_ok = 1'b1;
	end

	// ==========================================================
	// One test clock; tck parks low between frames
	// Data out is read just before rising, after the falling update settled
	task automatic cyc(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#HALF;
		o = tdo;
		last_oe = tdo_oe;
		tck = 1'b1;
		#HALF;
		tck = 1'b0;
	endtask

	// Held-high mode select walks the controller home, then to idle
	task automatic tms_reset(input int n);
		logic o;
		repeat (n) cyc(1'b1, 1'b1, o);
		cyc(1'b0, 1'b1, o);
	endtask

	// ==========================================================
	// Scan n bits from idle, LSB first; exit on the last bit
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
			output logic [31:0] dout);
		logic o;
		dout = '0;
		oe_ok = 1'b1;
		cyc(1'b1, 1'b1, o);
		if (ir) cyc(1'b1, 1'b1, o);
		cyc(1'b0, 1'b1, o);
		cyc(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, din[i], o);
			dout[i] = o;
			if (last_oe !== 1'b1) oe_ok = 1'b0;
		end
		cyc(1'b1, 1'b1, o);
		if (last_oe !== 1'b0) oe_ok = 1'b0;
		cyc(1'b0, 1'b1, o);
		if (last_oe !== 1'b0) oe_ok = 1'b0;
	endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the SRAM boundary-scan test port
`timescale 1ns/100ps
module testbench;
	import sbt_pkg::*;

	// ==========================================================
	// Signals
	// Arbitrary identification value, bit zero left low on purpose
	localparam logic [31:0] ID_ARB = 32'h3c96_a5f0;
	logic              clk;
	logic              rst;
	logic              tck;
	logic              tms;
	logic              tdi;
	logic              tdo;
	logic              tdo_oe;
	wire               tdo_line;
	logic [BSR_IN-1:0] pin_in;
	sbt_out_t          core_out;
	sbt_out_t          pad_out;
	logic [31:0]       q;
	int                errors;
	int                n_checks;

	assign tdo_line = tdo_oe ? tdo : 1'bz;

	sbt_tap #(.ID_VALUE(ID_ARB)) DUT (
		.clk      (clk),
		.rst      (rst),
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi),
		.tdo      (tdo),
		.tdo_oe   (tdo_oe),
		.pin_in   (pin_in),
		.core_out (core_out),
		.pad_out  (pad_out)
	);

	sbt_jtag_master PTNR (
		.tck    (tck),
		.tms    (tms),
		.tdi    (tdi),
		.tdo    (tdo_line),
		.tdo_oe (tdo_oe)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			errors++;
		end
	endtask

	// Pins cross from the test clock, so allow a bounded settling time
	task automatic wait_pad(input sbt_out_t exp);
		int k;
		k = 0;
		while (k < 40 && pad_out !== exp) begin
			@(negedge clk);
			k++;
		end
		chk({23'h0, pad_out}, {23'h0, exp});
	endtask

	task automatic results;
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_idcode;
		PTNR.scan(1'b0, 32, 32'h0, q);
		chk(q, ID_ARB | 32'h1);
		chk(PTNR.oe_ok, 1'b1);
	endtask

	// A real master never loads the reserved codes they are
	// loaded here only to prove that they fall back to the bypass
	task automatic t_bypass;
		logic [2:0] codes [4];
		codes = '{3'h3, 3'h5, 3'h6, IR_BYPASS};
		foreach (codes[i]) begin
			PTNR.scan(1'b1, 3, {29'h0, codes[i]}, q);
			chk(q[2:0], 3'h1);
			PTNR.scan(1'b0, 4, 32'hb, q);
			chk(q[3:0], 4'h6);
			chk(PTNR.oe_ok, 1'b1);
		end
	endtask

	task automatic t_sample_extest;
		@(negedge clk);
		core_out = '{8'ha5, 1'b1};
		pin_in = 8'h3c;
		PTNR.scan(1'b1, 3, {29'h0, IR_SAMPLE}, q);
		PTNR.scan(1'b0, 17, 32'h0_6900, q);
		chk(q[16:0], {1'b1, 8'ha5, 8'h3c});
		wait_pad('{8'ha5, 1'b1});
		PTNR.scan(1'b1, 3, {29'h0, IR_EXTEST}, q);
		wait_pad('{8'h69, 1'b0});
	endtask

	task automatic t_samplez;
		PTNR.scan(1'b1, 3, {29'h0, IR_SAMPLEZ}, q);
		wait_pad('{8'ha5, 1'b0});
		PTNR.scan(1'b0, 17, 32'h0, q);
		chk(q[16:0], {1'b0, 8'ha5, 8'h3c});
	endtask

	// Test-port reset must leave the memory path running untouched
	task automatic t_tms_reset;
		PTNR.tms_reset(5);
		wait_pad('{8'ha5, 1'b1});
		@(negedge clk);
		core_out = '{8'h5a, 1'b0};
		wait_pad('{8'h5a, 1'b0});
		PTNR.scan(1'b1, 3, {29'h0, IR_EXTEST}, q);
		wait_pad('{8'h00, 1'b1});
		PTNR.tms_reset(5);
		PTNR.scan(1'b0, 32, 32'h0, q);
		chk(q, ID_ARB | 32'h1);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		pin_in = '0;
		core_out = '0;
		errors = 0;
		n_checks = 0;
		// Reset reaches the test clock domain only while tck runs
		PTNR.tms_reset(4);
		@(negedge clk);
		rst = 1'b0;
		#1;
		chk(tdo_oe, 1'b0);
		PTNR.tms_reset(5);
		t_idcode();
		t_bypass();
		t_sample_extest();
		t_samplez();
		t_tms_reset();
		results();
	end
endmodule
